// *** design/comc_lp_mode.v ***
// Purpose: mode state machine of one logical processor
// Assumes: requests arrive already synchronised to clk_i
// Notes:   management entry saves ip, flags and mode; exit restores the mode and pulses restore_o
`timescale 1ns/1ps
`include "comc_map.vh"

module comc_lp_mode (
  // clock and reset
  input  wire                      clk_i,
  input  wire                      srst_i,
  // requests
  input  wire                      mgmt_req_i,
  input  wire                      mgmt_rsm_i,
  input  wire                      go_prot_i,
  input  wire                      go_real_i,
  input  wire                      v86_set_i,
  input  wire                      v86_val_i,
  input  wire                      halt_i,
  input  wire                      run_i,
  // live context
  input  wire [`COMC_IP_W-1:0]     cur_ip_i,
  input  wire [`COMC_FLAGS_W-1:0]  cur_flags_i,
  // status
  output wire [`COMC_MODE_W-1:0]   mode_o,
  output wire                      v86_o,
  output wire                      halted_o,
  output wire                      pending_o,
  output wire                      save_o,
  output wire                      restore_o,
  output wire [`COMC_IP_W-1:0]     saved_ip_o,
  output wire [`COMC_FLAGS_W-1:0]  saved_flags_o,
  output wire [`COMC_FEAT_W-1:0]   feat_o
);

  reg [`COMC_MODE_W-1:0]  mode_ff;      // current mode
  reg [`COMC_MODE_W-1:0]  prev_mode_ff; // mode before management entry
  reg                     prev_v86_ff;  // task attribute before entry
  reg                     v86_ff;       // per-task emulation attribute
  reg                     halt_ff;      // this processor halted
  reg                     pend_ff;      // request held while in mgmt
  reg                     save_ff;      // one-cycle save strobe
  reg                     rest_ff;      // one-cycle restore strobe
  reg [`COMC_IP_W-1:0]    sip_ff;       // saved instruction pointer
  reg [`COMC_FLAGS_W-1:0] sfl_ff;       // saved flags
  reg [`COMC_FEAT_W-1:0]  feat_ff;      // features open in this mode

  wire in_mgmt = (mode_ff == `COMC_MODE_MGMT);
  // a held request counts as a fresh one once we are back out
  wire take    = (mgmt_req_i | pend_ff) & ~in_mgmt;

  // mode sequencing, management has priority over other switches
  always @(posedge clk_i) begin
    if (srst_i) begin
      mode_ff      <= `COMC_MODE_RESET;
      prev_mode_ff <= `COMC_MODE_RESET;
      prev_v86_ff  <= 1'b0;
      v86_ff       <= 1'b0;
      halt_ff      <= 1'b0;
      pend_ff      <= 1'b0;
      save_ff      <= 1'b0;
      rest_ff      <= 1'b0;
      sip_ff       <= {`COMC_IP_W{1'b0}};
      sfl_ff       <= {`COMC_FLAGS_W{1'b0}};
      feat_ff      <= `COMC_FEAT_REAL;
    end else begin
      save_ff <= 1'b0;
      rest_ff <= 1'b0;
      // halt and run are per processor
      if (halt_i)
        halt_ff <= 1'b1;
      else if (run_i | take)
        halt_ff <= 1'b0;
      case (mode_ff)
        `COMC_MODE_REAL, `COMC_MODE_PROT: begin
          if (take) begin
            // save context and switch address space in the same cycle
            prev_mode_ff <= mode_ff;
            prev_v86_ff  <= v86_ff;
            sip_ff       <= cur_ip_i;
            sfl_ff       <= cur_flags_i;
            save_ff      <= 1'b1;
            pend_ff      <= 1'b0;
            mode_ff      <= `COMC_MODE_MGMT;
            feat_ff      <= `COMC_FEAT_MGMT;
          end else if (mode_ff == `COMC_MODE_REAL && go_prot_i) begin
            mode_ff <= `COMC_MODE_PROT;
            feat_ff <= `COMC_FEAT_ALL;
          end else if (mode_ff == `COMC_MODE_PROT && go_real_i) begin
            mode_ff <= `COMC_MODE_REAL;
            feat_ff <= `COMC_FEAT_REAL;
            v86_ff  <= 1'b0;
          end else if (mode_ff == `COMC_MODE_PROT && v86_set_i) begin
            v86_ff <= v86_val_i;
          end
        end
        `COMC_MODE_MGMT: begin
          // new request during a session is held, never nested
          if (mgmt_req_i)
            pend_ff <= 1'b1;
          if (mgmt_rsm_i) begin
            mode_ff <= prev_mode_ff;
            v86_ff  <= prev_v86_ff;
            rest_ff <= 1'b1;
            feat_ff <= (prev_mode_ff == `COMC_MODE_PROT) ?
                       `COMC_FEAT_ALL : `COMC_FEAT_REAL;
          end
        end
        default: begin
          // illegal code, fall back to the reset mode
          mode_ff <= `COMC_MODE_RESET;
          feat_ff <= `COMC_FEAT_REAL;
        end
      endcase
    end
  end

  assign mode_o        = mode_ff;
  assign v86_o         = v86_ff;
  assign halted_o      = halt_ff;
  assign pending_o     = pend_ff;
  assign save_o        = save_ff;
  assign restore_o     = rest_ff;
  assign saved_ip_o    = sip_ff;
  assign saved_flags_o = sfl_ff;
  assign feat_o        = feat_ff;

endmodule // comc_lp_mode

// *** design/comc_top.v ***
// Purpose: operating-mode control for a two-thread processor core
// Assumes: pin request is asynchronous and active low
// Notes:   one mode machine per logical processor, resources shared
`timescale 1ns/1ps
`include "comc_map.vh"

module comc_top (
  // clock and reset
  input  wire                              clk_i,
  input  wire                              srst_i,
  // management requests
  input  wire                              mgmt_irq_pin_n_i,
  input  wire [`COMC_NUM_LP-1:0]           prog_irq_msg_i,
  input  wire [`COMC_NUM_LP-1:0]           mgmt_rsm_i,
  // mode switches per logical processor
  input  wire [`COMC_NUM_LP-1:0]           go_prot_i,
  input  wire [`COMC_NUM_LP-1:0]           go_real_i,
  input  wire [`COMC_NUM_LP-1:0]           v86_set_i,
  input  wire [`COMC_NUM_LP-1:0]           v86_val_i,
  input  wire [`COMC_NUM_LP-1:0]           halt_i,
  input  wire [`COMC_NUM_LP-1:0]           run_i,
  // live context per processor, packed
  input  wire [2*`COMC_IP_W-1:0]           cur_ip_i,
  input  wire [2*`COMC_FLAGS_W-1:0]        cur_flags_i,
  // status per processor, packed
  output wire [2*`COMC_MODE_W-1:0]         mode_o,
  output wire [`COMC_NUM_LP-1:0]           v86_o,
  output wire [`COMC_NUM_LP-1:0]           halted_o,
  output wire [`COMC_NUM_LP-1:0]           pending_o,
  output wire [`COMC_NUM_LP-1:0]           save_o,
  output wire [`COMC_NUM_LP-1:0]           restore_o,
  output wire [2*`COMC_IP_W-1:0]           saved_ip_o,
  output wire [2*`COMC_FLAGS_W-1:0]        saved_flags_o,
  output wire [2*`COMC_FEAT_W-1:0]         feat_o,
  // fixed resource description
  output wire [7:0]                        lin_addr_w_o,
  output wire [7:0]                        phys_addr_w_o,
  output wire [7:0]                        num_gpr_o,
  output wire [7:0]                        num_seg_o,
  output wire [7:0]                        num_narrow_o,
  output wire [7:0]                        narrow_w_o,
  output wire [7:0]                        num_wide_o,
  output wire [7:0]                        wide_w_o,
  output wire [7:0]                        num_lp_o
);

  // two-flop synchroniser for the asynchronous pin
  reg pin_s1_ff;
  reg pin_s2_ff;
  reg pin_prev_ff;  // last synchronised level, for edge detect

  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_s1_ff   <= 1'b1;
      pin_s2_ff   <= 1'b1;
      pin_prev_ff <= 1'b1;
    end else begin
      pin_s1_ff   <= mgmt_irq_pin_n_i;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // falling edge only: a held-low pin must not retrigger after exit
  wire pin_fall = pin_prev_ff & ~pin_s2_ff;

  // one machine per logical processor, pin goes to both
  genvar g;
  generate
    for (g = 0; g < `COMC_NUM_LP; g = g + 1) begin : g_lp
      comc_lp_mode u_lp (
        .clk_i         (clk_i),
        .srst_i        (srst_i),
        .mgmt_req_i    (pin_fall | prog_irq_msg_i[g]),
        .mgmt_rsm_i    (mgmt_rsm_i[g]),
        .go_prot_i     (go_prot_i[g]),
        .go_real_i     (go_real_i[g]),
        .v86_set_i     (v86_set_i[g]),
        .v86_val_i     (v86_val_i[g]),
        .halt_i        (halt_i[g]),
        .run_i         (run_i[g]),
        .cur_ip_i      (cur_ip_i[g*`COMC_IP_W +: `COMC_IP_W]),
        .cur_flags_i   (cur_flags_i[g*`COMC_FLAGS_W +: `COMC_FLAGS_W]),
        .mode_o        (mode_o[g*`COMC_MODE_W +: `COMC_MODE_W]),
        .v86_o         (v86_o[g]),
        .halted_o      (halted_o[g]),
        .pending_o     (pending_o[g]),
        .save_o        (save_o[g]),
        .restore_o     (restore_o[g]),
        .saved_ip_o    (saved_ip_o[g*`COMC_IP_W +: `COMC_IP_W]),
        .saved_flags_o (saved_flags_o[g*`COMC_FLAGS_W +: `COMC_FLAGS_W]),
        .feat_o        (feat_o[g*`COMC_FEAT_W +: `COMC_FEAT_W])
      );
    end
  endgenerate

  // constant resource figures, read by the identification logic
  assign lin_addr_w_o  = `COMC_LIN_ADDR_W;
  assign phys_addr_w_o = `COMC_PHYS_ADDR_W;
  assign num_gpr_o     = `COMC_GPR_NUM;
  assign num_seg_o     = `COMC_SEG_NUM;
  assign num_narrow_o  = `COMC_NARROW_NUM;
  assign narrow_w_o    = `COMC_NARROW_W;
  assign num_wide_o    = `COMC_WIDE_NUM;
  assign wide_w_o      = `COMC_WIDE_W;
  assign num_lp_o      = `COMC_NUM_LP;

endmodule // comc_top

// *** include/comc_map.vh ***
// Purpose: constants for the operating-mode control block
// Assumes: one clock at 100 MHz, synchronous active-high reset
// Notes:   mode codes are one-hot, the same width as the state register
`ifndef COMC_MAP_VH
`define COMC_MAP_VH

// mode codes, one-hot
`define COMC_MODE_W        3
`define COMC_MODE_REAL     3'h1
`define COMC_MODE_PROT     3'h2
`define COMC_MODE_MGMT     3'h4
`define COMC_MODE_RESET    3'h1

// context and resource sizes
`define COMC_IP_W          32
`define COMC_FLAGS_W       32
// sized to the 8-bit resource ports, so nothing is cut on assignment
`define COMC_LIN_ADDR_W    8'h20
`define COMC_PHYS_ADDR_W   8'h24
`define COMC_GPR_NUM       8'h08
`define COMC_SEG_NUM       8'h06
`define COMC_NARROW_NUM    8'h08
`define COMC_NARROW_W      8'h40
`define COMC_WIDE_NUM      8'h08
`define COMC_WIDE_W        8'h80
`define COMC_NUM_LP        8'h02

// feature mask positions
`define COMC_FEAT_W        4
`define COMC_FEAT_BASIC    0
`define COMC_FEAT_NARROW   1
`define COMC_FEAT_WIDE     2
`define COMC_FEAT_SYSTEM   3
`define COMC_FEAT_ALL      4'hF
`define COMC_FEAT_REAL     4'h7
`define COMC_FEAT_MGMT     4'h7

`endif

// *** verif/comc_platform.sv ***
// Purpose: platform logic raising management requests
// Assumes: request pin idles high through a pull-up
// Notes:   pin is held low long enough to pass the synchroniser
`timescale 1ns/1ps
module comc_platform (
  // clock
  input  wire         clk_i,
  // requests toward the core
  output logic        mgmt_irq_pin_n_o,
  output logic [1:0]  prog_irq_msg_o
);
  initial begin
    mgmt_irq_pin_n_o = 1'b1;  // pulled-up idle level
    prog_irq_msg_o   = 2'h0;
  end
  // pin request: a falling edge, released afterwards
  task pin_fall();
    @(posedge clk_i);
    #1 mgmt_irq_pin_n_o = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 mgmt_irq_pin_n_o = 1'b1;
  endtask
  // controller message: one-cycle pulse to one processor
  task msg(input int lp);
    @(posedge clk_i);
    #1 prog_irq_msg_o[lp] = 1'b1;
    @(posedge clk_i);
    #1 prog_irq_msg_o = 2'h0;
  endtask
endmodule // comc_platform

// *** verif/comc_properties.sv ***
// Purpose: temporal checks of the mode control, processor 0
// Assumes: bound to comc_top, one clock domain
// Notes:   processor 1 is the same logic, scored by the bench
`timescale 1ns/1ps
`include "comc_map.vh"
module comc_checker (
  // clock and reset
  input wire        clk_i,
  input wire        srst_i,
  // requests
  input wire [1:0]  prog_irq_msg_i,
  input wire [1:0]  mgmt_rsm_i,
  input wire [1:0]  halt_i,
  // status
  input wire [5:0]  mode_o,
  input wire [1:0]  pending_o,
  input wire [1:0]  save_o,
  input wire [1:0]  restore_o,
  input wire [1:0]  halted_o,
  input wire [7:0]  feat_o
);
  localparam [2:0] RL = `COMC_MODE_REAL;
  localparam [2:0] PR = `COMC_MODE_PROT;
  localparam [2:0] MG = `COMC_MODE_MGMT;
  wire [2:0] m0 = mode_o[2:0];  // processor 0 mode
  reg  [2:0] prev_ff;           // mode to come back to
  // frozen inside a session, so it keeps the pre-entry mode
  always @(posedge clk_i) begin
    if (m0 != MG) prev_ff <= m0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_reset_real: assert property (disable iff (1'b0) srst_i |=> m0 == RL)
    else $error("mode not real after reset");
  a_msg_enter: assert property (prog_irq_msg_i[0] && m0 != MG |=> m0 == MG)
    else $error("message did not enter management");
  a_save_entry: assert property ($rose(m0[2]) |-> save_o[0] ##1 !save_o[0])
    else $error("entry without one save pulse");
  a_exit_mode: assert property (m0 == MG && mgmt_rsm_i[0] |=>
    restore_o[0] && m0 == prev_ff) else $error("exit mode wrong");
  a_pend_set: assert property (m0 == MG && prog_irq_msg_i[0] |=> pending_o[0])
    else $error("request in session not pending");
  a_pend_take: assert property (pending_o[0] && m0 != MG |=> m0 == MG)
    else $error("pending request not taken");
  a_feat_prot: assert property (m0 == PR |-> feat_o[3:0] == `COMC_FEAT_ALL)
    else $error("protected mode features wrong");
  a_halt_lp: assert property (m0 != MG && halt_i[0] && !pending_o[0] &&
    !prog_irq_msg_i[0] |=> halted_o[0]) else $error("halt not taken");
endmodule // comc_checker

bind comc_top comc_checker comc_checker_i (.clk_i, .srst_i, .prog_irq_msg_i,
  .mgmt_rsm_i, .halt_i, .mode_o, .pending_o, .save_o, .restore_o,
  .halted_o, .feat_o);

// *** verif/tb_comc_top.sv ***
// Purpose: self-checking bench for the mode control
// Assumes: platform model supplies the management requests
// Notes:   processor 0 save/restore pulses are scored from a queue
`timescale 1ns/1ps
`include "comc_map.vh"
module tb_comc_top;
  logic        clk_i  = 1'b0;
  logic        srst_i = 1'b1;
  logic [1:0]  rsm = 0, prot = 0, gr = 0, vs = 0, vv = 0, hl = 0, run = 0;
  logic [63:0] ip, flg;           // live context, random
  wire         pin_n;
  wire  [1:0]  msg, v86, hlt, pend, save, rest;
  wire  [5:0]  mode;
  wire  [7:0]  feat;
  wire  [63:0] sip, sflg;
  wire  [71:0] res;               // resource constants, packed
  logic [66:0] q[$];              // expected {mode, ip, flags}
  int          num_errors = 0;
  int          samples_checked = 0;
  localparam [2:0] RL = `COMC_MODE_REAL;
  localparam [2:0] PR = `COMC_MODE_PROT;
  localparam [2:0] MG = `COMC_MODE_MGMT;
  always #5 clk_i = ~clk_i;
  comc_platform comc_platform_i (.clk_i, .mgmt_irq_pin_n_o(pin_n),
    .prog_irq_msg_o(msg));
  comc_top comc_top_i (.clk_i, .srst_i, .mgmt_irq_pin_n_i(pin_n),
    .prog_irq_msg_i(msg), .mgmt_rsm_i(rsm), .go_prot_i(prot), .go_real_i(gr),
    .v86_set_i(vs), .v86_val_i(vv), .halt_i(hl), .run_i(run), .cur_ip_i(ip),
    .cur_flags_i(flg), .mode_o(mode), .v86_o(v86), .halted_o(hlt),
    .pending_o(pend), .save_o(save), .restore_o(rest), .saved_ip_o(sip),
    .saved_flags_o(sflg), .feat_o(feat), .lin_addr_w_o(res[71:64]),
    .phys_addr_w_o(res[63:56]), .num_gpr_o(res[55:48]),
    .num_seg_o(res[47:40]), .num_narrow_o(res[39:32]),
    .narrow_w_o(res[31:24]), .num_wide_o(res[23:16]),
    .wide_w_o(res[15:8]), .num_lp_o(res[7:0]));
  task chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task step();
    @(posedge clk_i);
    #1;
  endtask
  // one-cycle pulse on {rsm,prot,real,vset,vval,halt,run}, then settle
  task drv(input logic [13:0] v);
    step();
    {rsm, prot, gr, vs, vv, hl, run} = v;
    step();
    {rsm, prot, gr, vs, vv, hl, run} = 14'h0000;
    repeat (3) step();
  endtask
  task note(input logic [2:0] m);
    q.push_back({m, ip[31:0], flg[31:0]});
  endtask
  // scoreboard: every pulse of processor 0 takes the oldest note
  always @(negedge clk_i) begin
    if (!srst_i && (save[0] === 1'b1 || rest[0] === 1'b1)) begin
      if (q.size() == 0) chk("stray pulse", 72'h1, 72'h0);
      else chk("context", {mode[2:0], sip[31:0], sflg[31:0]}, q.pop_front());
    end
  end
  task close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(57084));
    ip = {$urandom, $urandom};
    flg = {$urandom, $urandom};
    repeat (16) @(posedge clk_i);
    #1 srst_i = 1'b0;
    chk("reset mode", mode, {2{RL}});
    chk("reset feat", feat, {2{`COMC_FEAT_REAL}});
    chk("resources", res, 72'h20_24_08_06_08_40_08_80_02);
    note(MG);
    comc_platform_i.msg(0);
    note(RL);
    drv(14'h1000);
    chk("msg round trip", mode, {2{RL}});
    drv(14'h0400);
    chk("prot", {feat[3:0], mode}, {4'hF, RL, PR});
    drv(14'h0050);
    chk("emulation attr", v86, 2'h1);
    ip = {$urandom, $urandom};
    note(MG);
    comc_platform_i.pin_fall();
    chk("pin entry", mode, {2{MG}});
    chk("lp1 saved", {sip[63:32], sflg[63:32]}, {ip[63:32], flg[63:32]});
    comc_platform_i.msg(0);
    step();
    chk("pending", pend, 2'h1);
    note(PR);
    note(MG);
    drv(14'h1000);
    chk("pending taken", {pend, mode[2:0]}, {2'h0, MG});
    note(PR);
    drv(14'h1000);
    chk("restored", {v86, mode[2:0]}, {2'h1, PR});
    drv(14'h2000);
    chk("lp1 restored", mode[5:3], RL);
    drv(14'h0100);
    chk("real again", {v86, mode}, {2'h0, RL, RL});
    drv(14'h0004);
    chk("halt lp0", hlt, 2'h1);
    drv(14'h0001);
    chk("run lp0", hlt, 2'h0);
    drv(14'h0400);
    srst_i = 1'b1;
    step();
    srst_i = 1'b0;
    chk("mid-run reset", mode, {2{RL}});
    chk("reset state", {sip[31:0], sflg[31:0], feat}, {64'h0, {2{`COMC_FEAT_REAL}}});
    chk("notes left", q.size(), 0);
    close_out();
  end
endmodule // tb_comc_top
